// file: rcfl_cap_if.sv
// Interface carrying capture state between the capture unit and the register bank
`timescale 1ns/1ps
`default_nettype none
interface rcfl_cap_if;
  logic rp_valid;
  logic rp_clear;
  logic [167:0] frame;
  modport cap (output rp_valid, output frame, input rp_clear);
  modport bank (input rp_valid, input frame, output rp_clear);
endinterface
`default_nettype wire

// file: rcfl_capture.sv
// Replay frame capture unit holding the sticky frame and its valid flag
`timescale 1ns/1ps
`default_nettype none
module rcfl_capture
  import rcfl_pkg::*;
(
  input wire logic ref_clk,
  input wire logic pwrgood_rst,
  input wire logic replay_crc_err,
  input wire logic replay_is_cfg_read,
  input wire logic replay_is_patrol,
  input wire logic cfg_read_logged,
  input wire logic [RCFL_FRAME_W-1:0] replay_frame,
  rcfl_cap_if.cap cap
);
  logic valid_q, valid_d;
  logic [RCFL_FRAME_W-1:0] frame_q, frame_d;
  logic take;

  // ----------------------------------------
  // Capture decision
  // ----------------------------------------
  always_comb begin
    // A clear in the same cycle as a new error unlocks the log, so the error is still captured
    take = replay_crc_err & (~valid_q | cap.rp_clear);  // [R01] [R16]
    if (replay_is_cfg_read | cfg_read_logged) begin
      take = 1'b0;  // [R02] [R09]
    end
    if (replay_is_patrol) begin
      take = 1'b0;  // [R15]
    end
    frame_d = take ? replay_frame : frame_q;  // [R14]
    // Capture wins over a clear in the same cycle, so the event is kept
    valid_d = take ? 1'b1 : (cap.rp_clear ? 1'b0 : valid_q);  // [R08]
  end

  // Sticky state: only the power-good reset clears it
  always_ff @(posedge ref_clk or posedge pwrgood_rst) begin
    if (pwrgood_rst) begin
      valid_q <= 1'b0;
      frame_q <= RCFL_FRAME_RST;
    end else begin
      valid_q <= valid_d;  // [R17]
      frame_q <= frame_d;
    end
  end

  assign cap.rp_valid = valid_q;
  assign cap.frame = frame_q;
endmodule
`default_nettype wire

// file: rcfl_nb.sv
// Northbound replay source model
`timescale 1ns/1ps
`default_nettype none
module rcfl_nb
  import rcfl_pkg::*;
(
  input wire logic go,
  input wire logic [1:0] kind,
  input wire logic [7:0] pat,
  output logic replay_crc_err,
  output logic replay_is_cfg_read,
  output logic replay_is_patrol,
  output logic [RCFL_FRAME_W-1:0] replay_frame
);
  // Ramp keeps words distinct; off-error the frame is inverted, never left stale
  localparam logic [167:0] ramp = 168'h14131211100F0E0D0C0B0A09080706050403020100;
  assign replay_frame = {21{go ? pat : ~pat}} ^ ramp;
  assign replay_crc_err = go;
  assign replay_is_cfg_read = go && kind == 2'h1;
  assign replay_is_patrol = go && kind == 2'h2;
endmodule
`default_nettype wire

// file: rcfl_pkg.sv
// Package with offsets, field positions and reset values for the replay error log
package rcfl_pkg;
  localparam logic [7:0] RCFL_OFF_WORD_A = 8'h40;
  localparam logic [7:0] RCFL_OFF_WORD_B = 8'h44;
  localparam logic [7:0] RCFL_OFF_WORD_C = 8'h48;
  localparam logic [7:0] RCFL_OFF_WORD_D = 8'h4C;
  localparam logic [7:0] RCFL_OFF_WORD_E = 8'h50;
  localparam logic [7:0] RCFL_OFF_WORD_F = 8'h54;
  localparam logic [7:0] RCFL_OFF_VALID = 8'h70;
  localparam int RCFL_FRAME_W = 168;
  localparam int RCFL_BIT_RP_VALID = 23;
  localparam int RCFL_BIT_RF_VALID = 22;
  localparam int RCFL_BIT_RF_CHAN = 21;
  localparam logic [31:0] RCFL_WORD_RST = 32'h0000_0000;
  localparam logic [RCFL_FRAME_W-1:0] RCFL_FRAME_RST = '0;
endpackage

// file: rcfl_sva.sv
// Checker bound to the replay error log top
`timescale 1ns/1ps
`default_nettype none
module rcfl_sva
  import rcfl_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic pwrgood_rst,
  input wire logic replay_crc_err,
  input wire logic replay_is_cfg_read,
  input wire logic replay_is_patrol,
  input wire logic recov_log_event,
  input wire logic cfg_rd,
  input wire logic [7:0] cfg_addr,
  input wire logic [31:0] cfg_rdata
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst || pwrgood_rst);
  // Log seen clear, one replay error, then a marker read
  sequence err_seen(logic c, logic p);
    cfg_rd && cfg_addr == 8'h70 && !recov_log_event ##1 cfg_rdata[23:22] == 2'h0 && !recov_log_event &&
    replay_crc_err && replay_is_cfg_read == c && replay_is_patrol == p ##1 cfg_rd && cfg_addr == 8'h70;
  endsequence
  chk_cap_valid: assert property (err_seen(1'h0, 1'h0) |=> cfg_rdata[23])
    else $error("no capture");
  chk_cfg_skip: assert property (err_seen(1'h1, 1'h0) |=> !cfg_rdata[23])
    else $error("cfg read captured");
  chk_patrol_skip: assert property (err_seen(1'h0, 1'h1) |=> !cfg_rdata[23])
    else $error("patrol captured");
  chk_rdata_hold: assert property (!cfg_rd |=> $stable(cfg_rdata))
    else $error("read data moved");
  chk_unmapped_zero: assert property (cfg_rd && cfg_addr == 8'h60 |=> cfg_rdata == 32'h0)
    else $error("unmapped not zero");
  // Two reads of word B with no replay error before the second
  sequence rd_b_twice;
    cfg_rd && cfg_addr == 8'h44 && !replay_crc_err ##1 cfg_rd && cfg_addr == 8'h44;
  endsequence
  chk_word_locked: assert property (rd_b_twice |=> $stable(cfg_rdata))
    else $error("log word moved");
  chk_warm_rdata: assert property (disable iff (pwrgood_rst) rst |-> cfg_rdata == 32'h0)
    else $error("warm reset data");
  chk_pwr_zero: assert property ($fell(pwrgood_rst) && cfg_rd && cfg_addr == 8'h44 |=> cfg_rdata == 32'h0)
    else $error("word not zero");
endmodule
bind rcfl_top rcfl_sva rcfl_sva_i (.*);
`default_nettype wire

// file: rcfl_top.sv
// Register bank for the recoverable replay CRC error frame log
`timescale 1ns/1ps
`default_nettype none
// What this block does
// (R01) First replayed CRC error frame captured, held
// (R02) Replayed config read data never captured
// (R03) Word B holds bits 63:32 at 44h
// (R04) Word C holds bits 95:64 at 48h
// (R05) Word D holds bits 127:96 at 4Ch
// (R06) Word E holds bits 159:128
// (R07) Word F low byte holds 167:160
// (R08) Bit 23: replay log valid, write-one-clear
// (R09) No replay capture after config read log
// (R10) Bit 22: frame and idle logs valid
// (R11) Bit 21: channel that triggered frame log
// (R12) Software trusts channel only with trigger set
// (R13) Marker register at 70h keeps indices
// (R14) Word A holds bits 31:0 at 40h
// (R15) Patrol scrub reads never trigger capture
// (R16) Triggered log locked until its bit cleared
// (R17) Sticky state survives warm reset
module rcfl_top
  import rcfl_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic pwrgood_rst,
  input wire logic replay_crc_err,
  input wire logic replay_is_cfg_read,
  input wire logic replay_is_patrol,
  input wire logic [RCFL_FRAME_W-1:0] replay_frame,
  input wire logic recov_log_event,
  input wire logic recov_log_event_chan,
  input wire logic recov_log_is_cfg_read,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [7:0] cfg_addr,
  input wire logic [31:0] cfg_wdata,
  output logic [31:0] cfg_rdata
);
  rcfl_cap_if cap_bus ();
  logic rf_valid_q, rf_valid_d;
  logic rf_chan_q, rf_chan_d;
  logic cfg_logged_q, cfg_logged_d;
  logic [31:0] rdata_q, rdata_d;
  logic wr_markers;
  logic [31:0] markers;

  // ----------------------------------------
  // Capture unit
  // ----------------------------------------
  rcfl_capture u_cap (
    .ref_clk(ref_clk),
    .pwrgood_rst(pwrgood_rst),
    .replay_crc_err(replay_crc_err),
    .replay_is_cfg_read(replay_is_cfg_read),
    .replay_is_patrol(replay_is_patrol),
    .cfg_read_logged(cfg_logged_q),
    .replay_frame(replay_frame),
    .cap(cap_bus.cap)
  );

  // ----------------------------------------
  // Valid markers
  // ----------------------------------------
  always_comb begin
    wr_markers = cfg_wr & (cfg_addr == RCFL_OFF_VALID);  // [R13]
    cap_bus.rp_clear = wr_markers & cfg_wdata[RCFL_BIT_RP_VALID];  // [R08]
    rf_valid_d = rf_valid_q;
    rf_chan_d = rf_chan_q;
    cfg_logged_d = cfg_logged_q;
    if (wr_markers & cfg_wdata[RCFL_BIT_RF_VALID]) begin
      rf_valid_d = 1'b0;
      cfg_logged_d = 1'b0;
    end
    if (wr_markers & cfg_wdata[RCFL_BIT_RF_CHAN]) begin
      rf_chan_d = 1'b0;
    end
    // Set beats clear; a locked frame log keeps its first channel
    if (recov_log_event & (~rf_valid_q | (wr_markers & cfg_wdata[RCFL_BIT_RF_VALID]))) begin
      rf_valid_d = 1'b1;  // [R10]
      rf_chan_d = recov_log_event_chan;  // [R11]
      cfg_logged_d = recov_log_is_cfg_read;  // [R09]
    end
  end

  always_ff @(posedge ref_clk or posedge pwrgood_rst) begin
    if (pwrgood_rst) begin
      rf_valid_q <= 1'b0;
      rf_chan_q <= 1'b0;
      cfg_logged_q <= 1'b0;
    end else begin
      rf_valid_q <= rf_valid_d;  // [R17]
      rf_chan_q <= rf_chan_d;
      cfg_logged_q <= cfg_logged_d;
    end
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  always_comb begin
    markers = RCFL_WORD_RST;
    markers[RCFL_BIT_RP_VALID] = cap_bus.rp_valid;
    markers[RCFL_BIT_RF_VALID] = rf_valid_q;
    markers[RCFL_BIT_RF_CHAN] = rf_chan_q;
    rdata_d = rdata_q;
    if (cfg_rd) begin
      case (cfg_addr)
        RCFL_OFF_WORD_A: rdata_d = cap_bus.frame[31:0];  // [R14]
        RCFL_OFF_WORD_B: rdata_d = cap_bus.frame[63:32];  // [R03]
        RCFL_OFF_WORD_C: rdata_d = cap_bus.frame[95:64];  // [R04]
        RCFL_OFF_WORD_D: rdata_d = cap_bus.frame[127:96];  // [R05]
        RCFL_OFF_WORD_E: rdata_d = cap_bus.frame[159:128];  // [R06]
        RCFL_OFF_WORD_F: rdata_d = {24'h000000, cap_bus.frame[167:160]};  // [R07]
        RCFL_OFF_VALID: rdata_d = markers;  // [R13]
        default: rdata_d = RCFL_WORD_RST;
      endcase
    end
  end

  // Read data is not sticky, so the warm reset clears it
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rdata_q <= RCFL_WORD_RST;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign cfg_rdata = rdata_q;
endmodule
`default_nettype wire

// file: replay_crc_error_frame_log_test.sv
// Self-checking bench for the replay error log
`timescale 1ns/1ps
`default_nettype none
module replay_crc_error_frame_log_test;
  import rcfl_pkg::*;
  typedef struct {logic [1:0] k; logic [7:0] s; logic v;} rcfl_row_t;
  rcfl_row_t rows [3] = '{'{2'h1, 8'h11, 1'h0}, '{2'h2, 8'h22, 1'h0}, '{2'h0, 8'hA5, 1'h1}};
  logic ref_clk = 0, rst = 1, pwrgood_rst = 1, go = 0, cfg_wr = 0, cfg_rd = 0, replay_crc_err;
  logic recov_log_event = 0, recov_log_event_chan = 0, recov_log_is_cfg_read = 0, replay_is_cfg_read, replay_is_patrol;
  logic [1:0] kind = 0;
  logic [7:0] pat = 0, last = 0, cfg_addr = 0;
  logic [31:0] cfg_wdata = 0, cfg_rdata;
  logic [RCFL_FRAME_W-1:0] replay_frame;
  int fail_count = 0, comparisons = 0;
  rcfl_nb rcfl_nb_i (.go(go), .kind(kind), .pat(pat), .replay_crc_err(replay_crc_err),
    .replay_is_cfg_read(replay_is_cfg_read), .replay_is_patrol(replay_is_patrol), .replay_frame(replay_frame));
  rcfl_top rcfl_top_i (.ref_clk(ref_clk), .rst(rst), .pwrgood_rst(pwrgood_rst), .replay_crc_err(replay_crc_err),
    .replay_is_cfg_read(replay_is_cfg_read), .replay_is_patrol(replay_is_patrol), .replay_frame(replay_frame),
    .recov_log_event(recov_log_event), .recov_log_event_chan(recov_log_event_chan),
    .recov_log_is_cfg_read(recov_log_is_cfg_read), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr),
    .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata));
  // One cycle of stimulus; seed and kind only matter while go is high
  task automatic step(logic r, logic w, logic g, logic e, logic [7:0] a, logic [31:0] d);
    cfg_rd = r;
    cfg_wr = w;
    go = g;
    recov_log_event = e;
    recov_log_event_chan = e;
    recov_log_is_cfg_read = e;
    cfg_addr = a;
    pat = a;
    kind = d[1:0];
    cfg_wdata = d;
    @(negedge ref_clk);
  endtask
  task automatic check(logic [7:0] a, logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value reg %h expected %h seen %h", a, exp, seen);
    end
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] e);
    step(1, 0, 0, 0, a, 32'h0);
    check(a, cfg_rdata, e);
  endtask
  function automatic logic [31:0] ew(int k);
    if (last == 8'h00) return 32'h0;
    if (k == 5) return {24'h0, last ^ 8'h14};
    return {4{last}} ^ {8'(4 * k + 3), 8'(4 * k + 2), 8'(4 * k + 1), 8'(4 * k)};
  endfunction
  task automatic words;
    for (int k = 0; k < 6; k++) rd(8'h40 + 8'(4 * k), ew(k));
  endtask
  task automatic test_done;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial forever #5 ref_clk = ~ref_clk;
  initial begin
    #20000;
    fail_count++;
    test_done;
  end
  initial begin
    repeat (5) @(negedge ref_clk);
    rst = 0;
    pwrgood_rst = 0;
    rd(8'h44, 32'h0);
    foreach (rows[i]) begin
      step(0, 1, 0, 0, 8'h70, 32'h00E0_0000);
      rd(8'h70, 32'h0);
      step(0, 0, 1, 0, rows[i].s, 32'(rows[i].k));
      rd(8'h70, {8'h0, rows[i].v, 23'h0});
      if (rows[i].v) last = rows[i].s;
      words;
      $display("row %0d done", i);
    end
    step(0, 0, 1, 0, 8'h3C, 32'h0);
    step(0, 1, 0, 0, 8'h44, 32'hFFFF_FFFF);
    rd(8'h44, ew(1));
    rd(8'h44, ew(1));
    step(0, 1, 0, 0, 8'h70, 32'h0);
    rd(8'h70, 32'h0080_0000);
    rd(8'h60, 32'h0);
    rst = 1;
    @(negedge ref_clk) rst = 0;
    words;
    $display("lock and warm reset done");
    step(0, 1, 0, 1, 8'h70, 32'h0080_0000);
    step(0, 0, 1, 0, 8'h77, 32'h0);
    rd(8'h70, 32'h0060_0000);
    step(0, 1, 0, 0, 8'h70, 32'h0060_0000);
    step(0, 0, 1, 0, 8'h77, 32'h0);
    last = 8'h77;
    rd(8'h70, 32'h0080_0000);
    words;
    $display("config read block done");
    test_done;
  end
endmodule
`default_nettype wire
